// ===== design/fcpwm_top.sv
`include "fcpwm_consts.svh"
`default_nettype none

// Function
// - Outputs stay off after reset until configured.
// - Host selects off, servo, duty, universal, frequency.
// - Servo: 20 ms period, 1-2 ms pulse.
// - Duty mode: own duty per channel.
// - Duty mode: one frequency per pair.
// - Universal: first channel rate and duty free.
// - Universal: second channel half rate, 50%.
// - Frequency mode: own rate, 50% duty.
// - Wide pair 16 bits, narrow pair 8.
module fcpwm_top #(
  parameter int SERVO_PERIOD_NS = `FCPWM_SERVO_PERIOD_NS,
  parameter int WIDE_BITS = `FCPWM_WIDE_BITS,
  parameter int NARROW_BITS = `FCPWM_NARROW_BITS
) (
  // Clock, reset and freeze.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Avalon-MM register slave.
  input wire logic [`FCPWM_ADDR_BITS-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire fcpwm_pkg::fcpwm_word_t avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output var fcpwm_pkg::fcpwm_word_t avs_readdata_out,
  output logic avs_waitrequest_out,
  // Pulse outputs.
  output logic wide_pair_first_out,
  output logic wide_pair_second_out,
  output logic narrow_pair_first_out,
  output logic narrow_pair_second_out
);
  import fcpwm_pkg::*;

  localparam int AW = `FCPWM_ADDR_BITS;

  // Registers sit on word boundaries; the two low address bits are ignored.
  function automatic logic reg_hit(input logic [AW-1:0] a, input logic [AW-1:0] ofs);
    reg_hit = (a[AW-1:2] == ofs[AW-1:2]);
  endfunction

  // Unknown codes fall back to off so that a stray write cannot start a load.
  function automatic fcpwm_mode_e cfg_mode(input logic [2:0] code);
    case (code)
      `FCPWM_CODE_SERVO: begin
        cfg_mode = MODE_SERVO;
      end
      `FCPWM_CODE_DUTY: begin
        cfg_mode = MODE_DUTY;
      end
      `FCPWM_CODE_UNIV: begin
        cfg_mode = MODE_UNIV;
      end
      `FCPWM_CODE_FREQ: begin
        cfg_mode = MODE_FREQ;
      end
      default: begin
        cfg_mode = MODE_OFF;
      end
    endcase
  endfunction

  function automatic fcpwm_half_t be_merge(
    input fcpwm_half_t old,
    input fcpwm_half_t val,
    input logic [1:0] be
  );
    be_merge = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
  endfunction

  logic wait_ff;
  fcpwm_word_t rdata_ff;
  logic [2:0] wide_code_ff;
  logic [2:0] narrow_code_ff;

  wire [3:0] pin;
  wire [1:0] run;
  wire fcpwm_half_t cnt_rd [2];
  wire fcpwm_word_t pair_rd [2];

  // Every access takes exactly one wait cycle, which keeps the slave simple.
  wire req = avs_read_in || avs_write_in;
  wire nxt_wait = !(req && wait_ff);
  wire wr_go = avs_write_in && !wait_ff;
  wire rd_take = avs_read_in && wait_ff;

  wire wr_ctrl = wr_go && avs_byteenable_in[0] && reg_hit(avs_address_in, `FCPWM_OFS_CTRL);
  wire [2:0] nxt_wide_code = avs_writedata_in[`FCPWM_CTRL_WIDE_LSB +: 3];
  wire [2:0] nxt_narrow_code = avs_writedata_in[`FCPWM_CTRL_NARROW_LSB +: 3];

  wire fcpwm_word_t ctrl_word = (32'(wide_code_ff) << `FCPWM_CTRL_WIDE_LSB) |
                                (32'(narrow_code_ff) << `FCPWM_CTRL_NARROW_LSB);
  wire fcpwm_word_t status_word = (32'(pin) << `FCPWM_STAT_PIN_LSB) |
                                  (32'(run) << `FCPWM_STAT_RUN_LSB);
  wire fcpwm_word_t count_word = (32'(cnt_rd[0]) << `FCPWM_CNT_WIDE_LSB) |
                                 (32'(cnt_rd[1]) << `FCPWM_CNT_NARROW_LSB);
  // Unmapped offsets read as zero and ignore writes.
  wire fcpwm_word_t rd_word =
    reg_hit(avs_address_in, `FCPWM_OFS_CTRL) ? ctrl_word :
    reg_hit(avs_address_in, `FCPWM_OFS_STATUS) ? status_word :
    reg_hit(avs_address_in, `FCPWM_OFS_COUNT) ? count_word :
    (pair_rd[0] | pair_rd[1]);

  assign avs_waitrequest_out = wait_ff;
  assign avs_readdata_out = rdata_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wait_ff <= 1'b1;
      rdata_ff <= `FCPWM_RST_WORD;
    end else if (clk_en_in) begin
      wait_ff <= nxt_wait;
      if (rd_take) begin
        rdata_ff <= rd_word;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      wide_code_ff <= `FCPWM_CODE_OFF;
      narrow_code_ff <= `FCPWM_CODE_OFF;
    end else if (clk_en_in && wr_ctrl) begin
      wide_code_ff <= nxt_wide_code;
      narrow_code_ff <= nxt_narrow_code;
    end
  end

  genvar p, c;
  for (p = 0; p < 2; p++) begin : g_pair
    localparam int W = (p == 0) ? WIDE_BITS : NARROW_BITS;
    localparam int TNS = (p == 0) ? `FCPWM_WIDE_TICK_NS : `FCPWM_NARROW_TICK_NS;
    localparam int SDIV = TNS / `FCPWM_CLK_NS;
    localparam int STOP = SERVO_PERIOD_NS / TNS - 1;
    // The servo window keeps its share of the period when the period is shortened.
    localparam int MIN_NS = SERVO_PERIOD_NS / (`FCPWM_SERVO_PERIOD_NS / `FCPWM_SERVO_MIN_NS);
    localparam int MAX_NS = SERVO_PERIOD_NS / (`FCPWM_SERVO_PERIOD_NS / `FCPWM_SERVO_MAX_NS);
    // The shortest pulse rounds up and the longest rounds down to whole ticks.
    localparam int CMIN = (MIN_NS + TNS - 1) / TNS;
    localparam int CMAX = MAX_NS / TNS;
    localparam logic [AW-1:0] BASE = (p == 0) ? `FCPWM_OFS_WIDE : `FCPWM_OFS_NARROW;
    localparam logic [AW-1:0] A_PRESC = BASE + `FCPWM_PAIR_PRESC;
    localparam logic [AW-1:0] A_TOP = BASE + `FCPWM_PAIR_TOP;
    localparam logic [AW-1:0] A_CMPA = BASE + `FCPWM_PAIR_CMPA;
    localparam logic [AW-1:0] A_CMPB = BASE + `FCPWM_PAIR_CMPB;

    fcpwm_half_t presc_ff;
    logic [W-1:0] top_ff;
    fcpwm_tb_if #(.W(W)) tb ();

    wire fcpwm_mode_e mode = cfg_mode((p == 0) ? wide_code_ff : narrow_code_ff);
    wire fcpwm_half_t wd = avs_writedata_in[15:0];
    wire [1:0] be = avs_byteenable_in[1:0];
    wire hit_presc = wr_go && reg_hit(avs_address_in, A_PRESC);
    wire hit_top = wr_go && reg_hit(avs_address_in, A_TOP);
    wire fcpwm_half_t nxt_presc = be_merge(presc_ff, wd, be);
    wire fcpwm_half_t nxt_top = be_merge(16'(top_ff), wd, be);

    // One period and prescale per pair, shared by both channels.
    always_ff @(posedge clk_in) begin
      if (sys_rst_in) begin
        presc_ff <= `FCPWM_RST_PRESC;
        top_ff <= W'(`FCPWM_RST_TOP);
      end else if (clk_en_in) begin
        if (hit_presc) begin
          presc_ff <= nxt_presc;
        end
        if (hit_top) begin
          top_ff <= W'(nxt_top);
        end
      end
    end

    fcpwm_timebase #(
      .W(W),
      .SDIV(SDIV),
      .STOP(STOP)
    ) u_base (
      .clk_in(clk_in),
      .sys_rst_in(sys_rst_in),
      .clk_en_in(clk_en_in),
      .mode_in(mode),
      .presc_in(presc_ff),
      .top_in(top_ff),
      .tb(tb)
    );

    for (c = 0; c < 2; c++) begin : g_chan
      localparam logic [AW-1:0] A_CMP = (c == 0) ? A_CMPA : A_CMPB;
      logic [W-1:0] cmp_ff;
      wire hit_cmp = wr_go && reg_hit(avs_address_in, A_CMP);
      wire fcpwm_half_t nxt_cmp = be_merge(16'(cmp_ff), wd, be);

      // Each channel keeps its own compare value.
      always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
          cmp_ff <= W'(`FCPWM_RST_CMP);
        end else if (clk_en_in && hit_cmp) begin
          cmp_ff <= W'(nxt_cmp);
        end
      end

      fcpwm_channel #(
        .W(W),
        .SECOND(c),
        .CMIN(CMIN),
        .CMAX(CMAX)
      ) u_chan (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .clk_en_in(clk_en_in),
        .cmp_in(cmp_ff),
        .tb(tb),
        .pin_out(pin[2 * p + c])
      );
    end

    assign run[p] = (tb.mode != MODE_OFF);
    assign cnt_rd[p] = 16'(tb.cnt);
    assign pair_rd[p] =
      reg_hit(avs_address_in, A_PRESC) ? 32'(presc_ff) :
      reg_hit(avs_address_in, A_TOP) ? 32'(top_ff) :
      reg_hit(avs_address_in, A_CMPA) ? 32'(g_chan[0].cmp_ff) :
      reg_hit(avs_address_in, A_CMPB) ? 32'(g_chan[1].cmp_ff) :
      `FCPWM_RST_WORD;
  end

  assign wide_pair_first_out = pin[0];
  assign wide_pair_second_out = pin[1];
  assign narrow_pair_first_out = pin[2];
  assign narrow_pair_second_out = pin[3];

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  bus_wait_a: assert property (req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("Slave did not answer after one wait cycle.");
  reset_off_a: assert property ($past(sys_rst_in) |-> pin == 4'h0 && run == 2'h0)
    else $error("Outputs not off after reset.");
  mode_sel_a: assert property (wr_ctrl |=> g_pair[0].mode == cfg_mode($past(nxt_wide_code)))
    else $error("Wide pair mode not taken from control write.");
  narrow_width_a: assert property (g_pair[1].hit_top && avs_byteenable_in[0]
      |=> 16'(g_pair[1].top_ff) == {8'h00, $past(avs_writedata_in[7:0])})
    else $error("Narrow period not held at eight bits.");

  ctrl_write_c: cover property (wr_ctrl && nxt_wide_code == `FCPWM_CODE_UNIV);
  both_run_c: cover property (run == 2'h3);
endmodule

`default_nettype wire

// ===== design/fcpwm_consts.svh
`ifndef FCPWM_CONSTS_SVH
`define FCPWM_CONSTS_SVH

// Clock and servo timing.
`define FCPWM_CLK_NS 25
`define FCPWM_SERVO_PERIOD_NS 20000000
`define FCPWM_SERVO_MIN_NS 1000000
`define FCPWM_SERVO_MAX_NS 2000000
`define FCPWM_WIDE_TICK_NS 1000
`define FCPWM_NARROW_TICK_NS 80000

// Pair resolutions.
`define FCPWM_WIDE_BITS 16
`define FCPWM_NARROW_BITS 8

// Register byte offsets.
`define FCPWM_ADDR_BITS 6
`define FCPWM_OFS_CTRL 6'h00
`define FCPWM_OFS_STATUS 6'h04
`define FCPWM_OFS_WIDE 6'h08
`define FCPWM_OFS_NARROW 6'h18
`define FCPWM_OFS_COUNT 6'h28
`define FCPWM_PAIR_PRESC 6'h00
`define FCPWM_PAIR_TOP 6'h04
`define FCPWM_PAIR_CMPA 6'h08
`define FCPWM_PAIR_CMPB 6'h0c

// Field positions.
`define FCPWM_CTRL_WIDE_LSB 0
`define FCPWM_CTRL_NARROW_LSB 4
`define FCPWM_STAT_PIN_LSB 0
`define FCPWM_STAT_RUN_LSB 4
`define FCPWM_CNT_WIDE_LSB 0
`define FCPWM_CNT_NARROW_LSB 16

// Mode codes in the control register.
`define FCPWM_CODE_OFF 3'h0
`define FCPWM_CODE_SERVO 3'h1
`define FCPWM_CODE_DUTY 3'h2
`define FCPWM_CODE_UNIV 3'h3
`define FCPWM_CODE_FREQ 3'h4

// Reset values.
`define FCPWM_RST_PRESC 16'h0000
`define FCPWM_RST_TOP 16'hffff
`define FCPWM_RST_CMP 16'h0000
`define FCPWM_RST_WORD 32'h0000_0000

`endif

// ===== design/fcpwm_pkg.sv
`default_nettype none

package fcpwm_pkg;
  typedef enum logic [2:0] {
    MODE_OFF,
    MODE_SERVO,
    MODE_DUTY,
    MODE_UNIV,
    MODE_FREQ
  } fcpwm_mode_e;
  typedef logic [31:0] fcpwm_word_t;
  typedef logic [15:0] fcpwm_half_t;
endpackage

`default_nettype wire

// ===== design/fcpwm_tb_if.sv
`default_nettype none

interface fcpwm_tb_if #(
  parameter int W = 16
);
  import fcpwm_pkg::*;
  logic tick;
  logic wrap;
  logic [W-1:0] cnt;
  fcpwm_mode_e mode;
  modport src(output tick, output wrap, output cnt, output mode);
  modport snk(input tick, input wrap, input cnt, input mode);
endinterface

`default_nettype wire

// ===== design/fcpwm_timebase.sv
`default_nettype none

module fcpwm_timebase #(
  parameter int W = 16,
  parameter int SDIV = 40,
  parameter int STOP = 19999
) (
  // Clock, reset and freeze.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Settings from the register file.
  input wire fcpwm_pkg::fcpwm_mode_e mode_in,
  input wire fcpwm_pkg::fcpwm_half_t presc_in,
  input wire logic [W-1:0] top_in,
  // Shared time base.
  fcpwm_tb_if.src tb
);
  import fcpwm_pkg::*;

  fcpwm_mode_e mode_ff;
  fcpwm_half_t div_ff;
  fcpwm_half_t pre_ff;
  logic [W-1:0] top_ff;
  logic [W-1:0] cnt_ff;

  wire idle = (mode_ff == MODE_OFF);
  wire tick = !idle && (pre_ff == div_ff);
  wire wrap = tick && (cnt_ff == top_ff);
  // Settings move in only at a period end or while off, so only a frequency-mode half period can be cut short.
  wire load = idle || wrap;
  wire servo = (mode_in == MODE_SERVO);
  wire fcpwm_half_t nxt_div = servo ? 16'(SDIV - 1) : presc_in;
  wire [W-1:0] nxt_top = servo ? W'(STOP) : top_in;
  wire fcpwm_half_t nxt_pre = (tick || idle) ? 16'h0000 : pre_ff + 16'h0001;
  wire [W-1:0] nxt_cnt = (wrap || idle) ? '0 : (tick ? cnt_ff + W'(1) : cnt_ff);

  assign tb.tick = tick;
  assign tb.wrap = wrap;
  assign tb.cnt = cnt_ff;
  assign tb.mode = mode_ff;

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      mode_ff <= MODE_OFF;
      div_ff <= `FCPWM_RST_PRESC;
      top_ff <= W'(`FCPWM_RST_TOP);
      pre_ff <= 16'h0000;
      cnt_ff <= '0;
    end else if (clk_en_in) begin
      pre_ff <= nxt_pre;
      cnt_ff <= nxt_cnt;
      if (load) begin
        mode_ff <= mode_in;
        div_ff <= nxt_div;
        top_ff <= nxt_top;
      end
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  wrap_restart_a: assert property (wrap |=> cnt_ff == '0 && pre_ff == 16'h0000)
    else $error("Counter did not restart after period end.");
  settle_a: assert property (!load |=> $stable(top_ff) && $stable(mode_ff))
    else $error("Period setting changed inside a period.");
  servo_base_a: assert property (mode_ff == MODE_SERVO && tick |-> pre_ff == 16'(SDIV - 1))
    else $error("Servo tick spacing wrong.");
  servo_period_a: assert property (mode_ff == MODE_SERVO && wrap |-> cnt_ff == W'(STOP))
    else $error("Servo period length wrong.");
endmodule

`default_nettype wire

// ===== design/fcpwm_channel.sv
`default_nettype none

module fcpwm_channel #(
  parameter int W = 16,
  parameter int SECOND = 0,
  parameter int CMIN = 1000,
  parameter int CMAX = 2000
) (
  // Clock, reset and freeze.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Setting and time base.
  input wire logic [W-1:0] cmp_in,
  fcpwm_tb_if.snk tb,
  // Pulse output.
  output logic pin_out
);
  import fcpwm_pkg::*;

  logic [W-1:0] cmp_ff;
  logic [W-1:0] half_ff;
  logic tog_ff;

  wire idle = (tb.mode == MODE_OFF);
  wire [W-1:0] lim_lo = W'(CMIN);
  wire [W-1:0] lim_hi = W'(CMAX);
  // The servo window is enforced here so a bad setting cannot hurt a servo.
  wire [W-1:0] servo_cmp = (cmp_ff < lim_lo) ? lim_lo :
                           ((cmp_ff > lim_hi) ? lim_hi : cmp_ff);
  wire below = tb.cnt < cmp_ff;
  wire half_end = tb.tick && (half_ff >= cmp_ff);
  wire flip = (tb.mode == MODE_FREQ) ? half_end :
              ((tb.mode == MODE_UNIV) && tb.wrap);
  wire nxt_pin = (tb.mode == MODE_SERVO) ? (tb.cnt < servo_cmp) :
                 (tb.mode == MODE_DUTY) ? below :
                 (tb.mode == MODE_UNIV) ? ((SECOND != 0) ? tog_ff : below) :
                 (tb.mode == MODE_FREQ) ? tog_ff : 1'b0;
  wire [W-1:0] nxt_half = (idle || half_end) ? '0 :
                          (tb.tick ? half_ff + W'(1) : half_ff);

  always_ff @(posedge clk_in) begin
    if (sys_rst_in) begin
      cmp_ff <= W'(`FCPWM_RST_CMP);
      half_ff <= '0;
      tog_ff <= 1'b0;
      pin_out <= 1'b0;
    end else if (clk_en_in) begin
      if (idle || tb.wrap) begin
        cmp_ff <= cmp_in;
      end
      half_ff <= nxt_half;
      tog_ff <= !idle && (tog_ff ^ flip);
      pin_out <= nxt_pin;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !clk_en_in);

  off_pin_a: assert property (idle |=> !pin_out)
    else $error("Output high while pair is off.");
  duty_pin_a: assert property ((tb.mode == MODE_DUTY ||
      (tb.mode == MODE_UNIV && SECOND == 0)) |=> pin_out == $past(below))
    else $error("Duty output does not follow compare.");
  servo_low_a: assert property (tb.mode == MODE_SERVO && tb.cnt < lim_lo |=> pin_out)
    else $error("Servo pulse shorter than minimum.");
  servo_high_a: assert property (tb.mode == MODE_SERVO && tb.cnt >= lim_hi |=> !pin_out)
    else $error("Servo pulse longer than maximum.");
  cmp_hold_a: assert property (!(idle || tb.wrap) |=> $stable(cmp_ff))
    else $error("Compare changed inside a period.");
  univ_half_a: assert property (SECOND != 0 && tb.mode == MODE_UNIV && tb.wrap
      |=> tog_ff != $past(tog_ff) ##1 pin_out == $past(tog_ff))
    else $error("Second channel does not toggle at period end.");
  freq_flip_a: assert property (tb.mode == MODE_FREQ && half_end
      |=> tog_ff != $past(tog_ff) && half_ff == '0)
    else $error("Frequency output missed its half period.");

  servo_pulse_c: cover property (tb.mode == MODE_SERVO && $rose(pin_out));
  freq_run_c: cover property (tb.mode == MODE_FREQ && $fell(pin_out));
endmodule

`default_nettype wire

// ===== verification/fcpwm_load.sv
`default_nettype none

// Behaves as a high-impedance servo or driver input that only senses the pulse train.
// It measures the last high time and the last rise-to-rise period in clocks.
module fcpwm_load (
  // Clock and reset.
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Pulse line from the block.
  input wire logic pin_in,
  // Measured shape.
  output var int high_len_out,
  output var int period_len_out,
  output var int rises_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int since_rise;
  logic last;
  wire logic rose = pin_in & ~last;
  wire logic fell = ~pin_in & last;

  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      since_rise <= 0;
      last <= 1'b0;
      rises_out <= 0;
      high_len_out <= 0;
      period_len_out <= 0;
    end else begin
      last <= pin_in;
      since_rise <= rose ? 1 : since_rise + 1;
      if (rose) begin
        period_len_out <= since_rise;
        rises_out <= rises_out + 1;
      end
      if (fell) begin
        high_len_out <= since_rise;
      end
    end
  end
endmodule

`default_nettype wire

// ===== verification/fcpwm_top_tb.sv
`include "fcpwm_consts.svh"
`default_nettype none

module fcpwm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import fcpwm_pkg::*;
  // A short servo period keeps the run small; the 1-2 ms window scales with it.
  localparam int SP_CLK = 4000;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  fcpwm_word_t avs_writedata = 32'h0000_0000;
  fcpwm_word_t avs_readdata;
  logic avs_waitrequest;
  logic [3:0] pins;
  int hi[4];
  int per[4];
  int rs[4];
  int seed = 90;
  int fail_count = 0;
  int tests_run = 0;
  fcpwm_word_t q;
  int top_w, top_n, pr_w, pr_n;
  int ca[4];

  fcpwm_top #(.SERVO_PERIOD_NS(SP_CLK * 25)) fcpwm_top_i (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(4'hf),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .wide_pair_first_out(pins[0]), .wide_pair_second_out(pins[1]),
    .narrow_pair_first_out(pins[2]), .narrow_pair_second_out(pins[3]));

  for (genvar g = 0; g < 4; g++) begin : g_load
    fcpwm_load fcpwm_load_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .pin_in(pins[g]),
      .high_len_out(hi[g]), .period_len_out(per[g]), .rises_out(rs[g]));
  end

  initial begin
    forever #12.5 clk_in = ~clk_in;
  end

  function automatic int rnd(input int lo, input int hi_v);
    return lo + int'($unsigned($random(seed)) % (hi_v - lo + 1));
  endfunction

  function automatic int clocks(input int n, input int presc);
    return n * (presc + 1);
  endfunction

  task automatic results;
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk_word(input string what, input fcpwm_word_t exp, input fcpwm_word_t got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  task automatic chk_len(input string what, input int ch, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      fail_count++;
      $display("unexpected %s ch%0d: expected %0d, seen %0d", what, ch, exp, got);
    end
  endtask

  // Holds the request until waitrequest is sampled low, then lets one edge pass.
  task automatic bus(input logic wr, input logic [5:0] a, input fcpwm_word_t d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge clk_in);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    q = avs_readdata;
    if (n >= 50) begin
      fail_count++;
      $display("unexpected bus answer: expected waitrequest low, seen high");
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [5:0] a, input int d);
    bus(1'b1, a, fcpwm_word_t'(d));
  endtask

  task automatic rd(input logic [5:0] a, input fcpwm_word_t exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk_word(what, exp, q);
  endtask

  task automatic set_pair(input int p, input int pr, input int tp, input int a, input int b);
    logic [5:0] base;
    base = (p != 0) ? `FCPWM_OFS_NARROW : `FCPWM_OFS_WIDE;
    wr(base + `FCPWM_PAIR_PRESC, pr);
    wr(base + `FCPWM_PAIR_TOP, tp);
    wr(base + `FCPWM_PAIR_CMPA, a);
    wr(base + `FCPWM_PAIR_CMPB, b);
  endtask

  // The first rise after a change may close an old-setting period, so wait for three.
  task automatic shape(input int ch, input int h, input int p);
    int r0, t;
    r0 = rs[ch];
    t = 0;
    while (rs[ch] < r0 + 3 && t < 20000) begin
      @(posedge clk_in);
      t++;
    end
    chk_len("high time", ch, h, hi[ch]);
    chk_len("period", ch, p, per[ch]);
  endtask

  initial begin
    repeat (99000) @(posedge clk_in);
    fail_count++;
    $display("unexpected run length: expected end of tests, seen timeout");
    results();
  end

  initial begin
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    @(posedge clk_in);
    chk_word("pins after reset", 32'h0, {28'h0, pins});
    chk_word("waitrequest idle", 32'h1, {31'h0, avs_waitrequest});
    rd(`FCPWM_OFS_CTRL, 32'h0, "control reset");
    rd(`FCPWM_OFS_WIDE + `FCPWM_PAIR_TOP, 32'h0000_ffff, "wide top reset");
    rd(`FCPWM_OFS_NARROW + `FCPWM_PAIR_TOP, 32'h0000_00ff, "narrow top reset");
    wr(`FCPWM_OFS_NARROW + `FCPWM_PAIR_CMPA, 32'h0000_1234);
    rd(`FCPWM_OFS_NARROW + `FCPWM_PAIR_CMPA, 32'h0000_0034, "narrow width");
    wr(6'h3c, 32'hffff_ffff);
    rd(6'h3c, 32'h0, "unmapped read");
    repeat (100) @(posedge clk_in);
    chk_len("pulses while off", 0, 0, rs[0] + rs[1] + rs[2] + rs[3]);
    for (int it = 0; it < 4; it++) begin
      top_w = (it == 1) ? 300 : rnd(8, 40);
      top_n = rnd(4, 20);
      pr_w = rnd(0, 2);
      pr_n = rnd(0, 3);
      ca[0] = rnd(1, top_w);
      ca[1] = (it == 0) ? top_w : rnd(1, top_w);
      ca[2] = rnd(1, top_n);
      ca[3] = (it == 0) ? 1 : rnd(1, top_n);
      set_pair(0, pr_w, top_w, ca[0], ca[1]);
      set_pair(1, pr_n, top_n, ca[2], ca[3]);
      wr(`FCPWM_OFS_CTRL, 32'h22);
      for (int c = 0; c < 2; c++) begin
        shape(c, clocks(ca[c], pr_w), clocks(top_w + 1, pr_w));
        shape(c + 2, clocks(ca[c + 2], pr_n), clocks(top_n + 1, pr_n));
      end
    end
    bus(1'b0, `FCPWM_OFS_STATUS, 32'h0);
    chk_word("run flags", 32'h3, {30'h0, q[5:4]});
    wr(`FCPWM_OFS_CTRL, 32'h33);
    shape(0, clocks(ca[0], pr_w), clocks(top_w + 1, pr_w));
    shape(1, clocks(top_w + 1, pr_w), 2 * clocks(top_w + 1, pr_w));
    shape(2, clocks(ca[2], pr_n), clocks(top_n + 1, pr_n));
    shape(3, clocks(top_n + 1, pr_n), 2 * clocks(top_n + 1, pr_n));
    // A product of at least 1000 keeps every rate at or below the ceiling.
    for (int c = 0; c < 4; c++) begin
      ca[c] = rnd(99, 130);
    end
    set_pair(0, 9, top_w, ca[0], ca[1]);
    set_pair(1, 9, top_n, ca[2], ca[3]);
    wr(`FCPWM_OFS_CTRL, 32'h44);
    for (int c = 0; c < 4; c++) begin
      shape(c, clocks(ca[c] + 1, 9), 2 * clocks(ca[c] + 1, 9));
    end
    // Compares outside the servo window must be clamped to its edges.
    set_pair(0, 0, 16'hffff, 0, 16'hffff);
    wr(`FCPWM_OFS_CTRL, 32'h51);
    shape(0, SP_CLK / 20, SP_CLK);
    shape(1, SP_CLK / 10, SP_CLK);
    chk_word("narrow pins off", 32'h0, {30'h0, pins[3:2]});
    bus(1'b0, `FCPWM_OFS_STATUS, 32'h0);
    chk_word("run flags", 32'h1, {30'h0, q[5:4]});
    wr(`FCPWM_OFS_CTRL, 32'h00);
    repeat (SP_CLK + 10) @(posedge clk_in);
    chk_word("pins after off", 32'h0, {28'h0, pins});
    rd(`FCPWM_OFS_STATUS, 32'h0, "status after off");
    results();
  end
endmodule

`default_nettype wire
